// File: src/dbe_regs.svh
`ifndef DBE_REGS_SVH
`define DBE_REGS_SVH
`define DBE_ADDR_CTRL     8'h00
`define DBE_ADDR_STATUS   8'h04
`define DBE_ADDR_INT_STAT 8'h08
`define DBE_ADDR_INT_MASK 8'h0C
`define DBE_ADDR_BP_EN    8'h10
`define DBE_ADDR_BP_BASE  8'h20
`define DBE_REG_STRIDE    8'h04
`define DBE_CTRL_FLOW     0
`define DBE_CTRL_STACK    1
`define DBE_CTRL_WDT      2
`define DBE_CTRL_RESET    3
`define DBE_CTRL_RESUME   4
`define DBE_CTRL_PM_LO    5
`define DBE_CTRL_PM_HI    6
`define DBE_CTRL_RST      7'h00
`define DBE_CTRL_WMASK    7'h6F
`define DBE_ST_ACTIVE     0
`define DBE_ST_HALTED     1
`define DBE_ST_ISP_ENTRY  2
`define DBE_ST_BOOT       3
`define DBE_ST_LOCK       4
`define DBE_INT_HALT      0
`define DBE_INT_FRAME     1
`define DBE_INT_RST       2'h0
`define DBE_BP_EN_RST     8'h00
`define DBE_BP_ADDR_RST   16'h0000
`define DBE_BREAK_CYCLES  2'h2
`define DBE_STRAP_WAIT    2'h3
`define DBE_FRAME_LAST    5'h18
`define DBE_FRAME_WR      24
`define DBE_FRAME_A_HI    23
`define DBE_FRAME_A_LO    8
`define DBE_FRAME_D_HI    7
`define DBE_TX_BITS       4'h8
`endif

// File: src/dbe_pkg.sv
package dbe_pkg;
    typedef enum logic [2:0] {
        DBE_LS_RX   = 3'h1,
        DBE_LS_READ = 3'h2,
        DBE_LS_TX   = 3'h4
    } dbe_link_e;

    typedef struct packed {
        logic [1:0]       dcl_sync;
        logic             dcl_prev;
        logic [1:0]       dda_sync;
        logic [1:0]       strap_cnt;
        logic             isp_entry;
        logic             active;
        dbe_link_e        link;
        logic [4:0]       bit_cnt;
        logic [24:0]      rx_sh;
        logic [7:0]       tx_sh;
        logic [3:0]       tx_cnt;
        logic             mem_we;
        logic             mem_re;
        logic [15:0]      mem_addr;
        logic [7:0]       mem_wdata;
        logic             dda_o;
        logic             dda_oe;
        logic [6:0]       ctrl;
        logic [1:0]       int_stat;
        logic [1:0]       int_mask;
        logic [7:0]       bp_en;
        logic [7:0][15:0] bp_addr;
        logic             halted;
        logic [1:0]       nop_cnt;
        logic             nop_busy;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic             irq;
        logic             core_rst_req;
        logic             rst_pin_o;
        logic             rst_pin_oe;
        logic             isp_en;
        logic             p43_o;
        logic             p43_oe;
        logic             p43_gpio_in;
    } dbe_state_s;
endpackage

// File: src/dbe_bkpt.sv
`timescale 1ns/1ps
module dbe_bkpt (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             fetch_valid,
    input  wire logic [15:0]      fetch_addr,
    input  wire logic             data_valid,
    input  wire logic [15:0]      data_addr,
    input  wire logic [7:0]       bp_en,
    input  wire logic [1:0]       pair_mask,
    input  wire logic [7:0][15:0] bp_addr,
    output logic      [7:0]       hit
);
    localparam int NPROG = 4;
    logic [7:0] hit_reg;
    logic [7:0] hit_next;

    genvar i;
    for (i = 0; i < 8; i++) begin : g_bp
        if (i < NPROG) begin : g_prog
            assign hit_next[i] = bp_en[i] & fetch_valid & (fetch_addr == bp_addr[i]); // RULE12
        end else if ((i % 2) == 0) begin : g_base
            // the partner entry turns into a don't-care mask when its pair is in mask mode
            logic [15:0] msk;
            assign msk = pair_mask[(i - NPROG) / 2] ? bp_addr[i + 1] : 16'h0000;
            assign hit_next[i] = bp_en[i] & // RULE13
                ((fetch_valid & (((fetch_addr ^ bp_addr[i]) & ~msk) == 16'h0000)) |
                 (data_valid & (((data_addr ^ bp_addr[i]) & ~msk) == 16'h0000)));
        end else begin : g_partner
            assign hit_next[i] = bp_en[i] & ~pair_mask[(i - NPROG) / 2] & // RULE13
                ((fetch_valid & (fetch_addr == bp_addr[i])) |
                 (data_valid & (data_addr == bp_addr[i])));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_reg <= 8'h00;
        end else begin
            hit_reg <= hit_next;
        end
    end
    assign hit = hit_reg;

    prog_bp_hit_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        bp_en[0] && fetch_valid && fetch_addr == bp_addr[0] |=> hit[0])
        else $error("program breakpoint 0 missed");
    pair_masked_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        pair_mask[0] |=> !hit[5])
        else $error("mask member of pair 0 raised a hit");
endmodule

// File: src/dbe_ctrl.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dbe_regs.svh"
// Function
// RULE1 - debug is active only while the debug enable fuse reads cleared.
// RULE2 - while active, the reset pin is only an input carrying the debug clock; the code still drives it while por_active is set.
// RULE3 - while active, port4_bit3 is the two-way debug data line shared with the emulator.
// RULE4 - while active, the reset input is ignored and serial programming stays off; the code still opens it when isp_entry is set.
// RULE5 - with debug on, serial programming opens only if reset was held at power-up.
// RULE6 - a running bootloader (boot jump fuse 0 or hardware entry) blocks debug.
// RULE7 - any programmed lock bit forces debug off whatever the fuse says.
// RULE8 - while active, no reset-pin pulse for watchdog events, but power-on still pulses.
// RULE9 - the emulator must emulate any target reset over the debug link.
// RULE10 - while active, port4_bit3 has no general I/O function and its port logic is cut off.
// RULE11 - with debug off, the break opcode is a two-cycle no-operation.
// RULE12 - four hardware breakpoints compare against the fetch address.
// RULE13 - four program/data breakpoints form two pairs where one member can mask the other.
// RULE14 - execution can halt on flow change, stack over/underflow, watchdog or reset.
// RULE15 - the emulator can read and write every special function register and data memory.
// RULE16 - with debug on, the break opcode halts with the next instruction pending, flags kept.
// RULE17 - link bits are sampled on debug clock rise and driven on its fall; framing is a stub.
module dbe_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        debug_en_fuse,
    input  wire logic        boot_jump_fuse,
    input  wire logic        hw_boot_entry,
    input  wire logic        lock_any,
    input  wire logic        por_active,
    input  wire logic        wdt_rst_pulse,
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe,
    output logic             core_rst_req,
    output logic             serial_programming_port_en,
    input  wire logic        port4_bit3_i,
    output logic             port4_bit3_o,
    output logic             port4_bit3_oe,
    input  wire logic        gpio_p43_o,
    input  wire logic        gpio_p43_oe,
    output logic             gpio_p43_in,
    input  wire logic        break_op,
    input  wire logic        flow_change,
    input  wire logic        stack_fault,
    input  wire logic        wdt_ovf,
    input  wire logic        sys_reset_evt,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        data_valid,
    input  wire logic [15:0] data_addr,
    output logic             halt_req,
    output logic             break_nop_busy,
    output logic             sfr_mem_we,
    output logic             sfr_mem_re,
    output logic [15:0]      sfr_mem_addr,
    output logic [7:0]       sfr_mem_wdata,
    input  wire logic [7:0]  sfr_mem_rdata
);
    dbe_pkg::dbe_state_s s;
    dbe_pkg::dbe_state_s n;
    logic [7:0]          bp_hit;
    logic                en_cond;
    logic                boot_run;
    logic                dcl_rise;
    logic                dcl_fall;
    logic                wr_acc;
    logic                resume;
    logic                halt_evt;

    dbe_bkpt u_bkpt (
        .pclk        (pclk),
        .presetn     (presetn),
        .fetch_valid (fetch_valid & s.active),
        .fetch_addr  (fetch_addr),
        .data_valid  (data_valid & s.active),
        .data_addr   (data_addr),
        .bp_en       (s.bp_en),
        .pair_mask   (s.ctrl[`DBE_CTRL_PM_HI:`DBE_CTRL_PM_LO]),
        .bp_addr     (s.bp_addr),
        .hit         (bp_hit)
    );

    assign boot_run = ~boot_jump_fuse | hw_boot_entry; // RULE6
    assign en_cond  = ~debug_en_fuse & ~lock_any & ~boot_run; // RULE1 RULE7
    assign dcl_rise = s.dcl_sync[1] & ~s.dcl_prev;
    assign dcl_fall = ~s.dcl_sync[1] & s.dcl_prev;
    assign wr_acc   = psel & penable & s.pready & pwrite;
    assign resume   = wr_acc & (paddr == `DBE_ADDR_CTRL) & pwdata[`DBE_CTRL_RESUME];
    assign halt_evt = s.active & ((|bp_hit) | break_op | // RULE12 RULE13 RULE16
        (flow_change & s.ctrl[`DBE_CTRL_FLOW]) | (stack_fault & s.ctrl[`DBE_CTRL_STACK]) |
        (wdt_ovf & s.ctrl[`DBE_CTRL_WDT]) | (sys_reset_evt & s.ctrl[`DBE_CTRL_RESET])); // RULE14

    always_comb begin
        n = s;
        n.dcl_sync = {s.dcl_sync[0], rst_pin_i};
        n.dcl_prev = s.dcl_sync[1];
        n.dda_sync = {s.dda_sync[0], port4_bit3_i};
        n.active   = en_cond;
        // strap of the reset pin, caught once the synchroniser has settled after power-up
        if (s.strap_cnt != `DBE_STRAP_WAIT) begin
            n.strap_cnt = s.strap_cnt + 2'h1;
            if (n.strap_cnt == `DBE_STRAP_WAIT) begin
                n.isp_entry = s.dcl_sync[1]; // RULE5
            end
        end
        n.core_rst_req = s.dcl_sync[1] & ~s.active & (s.strap_cnt == `DBE_STRAP_WAIT); // RULE4
        n.isp_en       = ~s.active | s.isp_entry; // RULE4 RULE5
        n.rst_pin_oe   = por_active | (wdt_rst_pulse & ~s.active); // RULE2 RULE8
        n.rst_pin_o    = n.rst_pin_oe;
        n.p43_o        = s.active ? s.dda_o : gpio_p43_o; // RULE3 RULE10
        n.p43_oe       = s.active ? s.dda_oe : gpio_p43_oe; // RULE10
        n.p43_gpio_in  = ~s.active & s.dda_sync[1]; // RULE10
        // link: bits in on the debug clock rise, out on its fall
        n.mem_we = 1'b0;
        n.mem_re = 1'b0;
        if (!s.active) begin
            n.link    = dbe_pkg::DBE_LS_RX;
            n.bit_cnt = 5'h00;
            n.tx_cnt  = 4'h0;
            n.dda_oe  = 1'b0;
            n.dda_o   = 1'b0;
        end else begin
            unique case (s.link)
                dbe_pkg::DBE_LS_RX: begin
                    if (dcl_rise) begin // RULE17
                        n.rx_sh = {s.rx_sh[23:0], s.dda_sync[1]};
                        if (s.bit_cnt == `DBE_FRAME_LAST) begin
                            n.bit_cnt   = 5'h00;
                            n.mem_addr  = n.rx_sh[`DBE_FRAME_A_HI:`DBE_FRAME_A_LO];
                            n.mem_wdata = n.rx_sh[`DBE_FRAME_D_HI:0];
                            n.int_stat[`DBE_INT_FRAME] = 1'b1;
                            if (n.rx_sh[`DBE_FRAME_WR]) begin
                                n.mem_we = 1'b1; // RULE15
                            end else begin
                                n.mem_re = 1'b1; // RULE15
                                n.link   = dbe_pkg::DBE_LS_READ;
                            end
                        end else begin
                            n.bit_cnt = s.bit_cnt + 5'h01;
                        end
                    end
                end
                dbe_pkg::DBE_LS_READ: begin
                    // read data are taken in the same cycle as the strobe
                    n.tx_sh  = sfr_mem_rdata;
                    n.tx_cnt = `DBE_TX_BITS;
                    n.link   = dbe_pkg::DBE_LS_TX;
                end
                dbe_pkg::DBE_LS_TX: begin
                    if (dcl_fall) begin // RULE3 RULE17
                        if (s.tx_cnt == 4'h0) begin
                            n.dda_oe = 1'b0;
                            n.link   = dbe_pkg::DBE_LS_RX;
                        end else begin
                            n.dda_oe = 1'b1;
                            n.dda_o  = s.tx_sh[7];
                            n.tx_sh  = {s.tx_sh[6:0], 1'b0};
                            n.tx_cnt = s.tx_cnt - 4'h1;
                        end
                    end
                end
                default: begin
                    n.link = dbe_pkg::DBE_LS_RX;
                end
            endcase
        end
        // break opcode: halt when active, otherwise a plain two-cycle gap
        if (break_op && !s.active) begin
            n.nop_cnt = `DBE_BREAK_CYCLES; // RULE11
        end else if (s.nop_cnt != 2'h0) begin
            n.nop_cnt = s.nop_cnt - 2'h1;
        end
        n.nop_busy = (n.nop_cnt != 2'h0); // RULE11
        // register writes; the clear is applied first so a same-cycle event wins
        if (wr_acc) begin
            unique case (paddr)
                `DBE_ADDR_CTRL:     n.ctrl = pwdata[6:0] & `DBE_CTRL_WMASK;
                `DBE_ADDR_INT_STAT: n.int_stat = s.int_stat & ~pwdata[1:0];
                `DBE_ADDR_INT_MASK: n.int_mask = pwdata[1:0];
                `DBE_ADDR_BP_EN:    n.bp_en = pwdata[7:0];
                default: begin
                    for (int k = 0; k < 8; k++) begin
                        if (paddr == `DBE_ADDR_BP_BASE + 8'(k) * `DBE_REG_STRIDE) begin
                            n.bp_addr[k] = pwdata[15:0];
                        end
                    end
                end
            endcase
        end
        if (resume || !s.active) begin
            n.halted = 1'b0;
        end
        if (halt_evt) begin
            n.halted = 1'b1; // RULE16
            n.int_stat[`DBE_INT_HALT] = 1'b1;
        end
        if (s.link == dbe_pkg::DBE_LS_RX && dcl_rise && s.active &&
            s.bit_cnt == `DBE_FRAME_LAST) begin
            n.int_stat[`DBE_INT_FRAME] = 1'b1;
        end
        n.irq = |(s.int_stat & s.int_mask);
        // bus: answer one cycle after setup, read data latched in the setup cycle
        n.pready  = psel & ~penable;
        n.pslverr = 1'b0;
        if (psel && !penable) begin
            n.prdata  = 32'h0000_0000;
            n.pslverr = 1'b1;
            unique case (paddr)
                `DBE_ADDR_CTRL: begin
                    n.prdata[6:0] = s.ctrl;
                    n.pslverr     = 1'b0;
                end
                `DBE_ADDR_STATUS: begin
                    n.prdata[`DBE_ST_ACTIVE]    = s.active;
                    n.prdata[`DBE_ST_HALTED]    = s.halted;
                    n.prdata[`DBE_ST_ISP_ENTRY] = s.isp_entry;
                    n.prdata[`DBE_ST_BOOT]      = boot_run;
                    n.prdata[`DBE_ST_LOCK]      = lock_any;
                    n.pslverr = 1'b0;
                end
                `DBE_ADDR_INT_STAT: begin
                    n.prdata[1:0] = s.int_stat;
                    n.pslverr     = 1'b0;
                end
                `DBE_ADDR_INT_MASK: begin
                    n.prdata[1:0] = s.int_mask;
                    n.pslverr     = 1'b0;
                end
                `DBE_ADDR_BP_EN: begin
                    n.prdata[7:0] = s.bp_en;
                    n.pslverr     = 1'b0;
                end
                default: begin
                    for (int k = 0; k < 8; k++) begin
                        if (paddr == `DBE_ADDR_BP_BASE + 8'(k) * `DBE_REG_STRIDE) begin
                            n.prdata[15:0] = s.bp_addr[k];
                            n.pslverr      = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.link     <= dbe_pkg::DBE_LS_RX;
            s.ctrl     <= `DBE_CTRL_RST;
            s.int_stat <= `DBE_INT_RST;
            s.int_mask <= `DBE_INT_RST;
            s.bp_en    <= `DBE_BP_EN_RST;
            s.bp_addr  <= {8{`DBE_BP_ADDR_RST}};
        end else begin
            s <= n;
        end
    end

    assign prdata                     = s.prdata;
    assign pready                     = s.pready;
    assign pslverr                    = s.pslverr;
    assign irq                        = s.irq;
    assign rst_pin_o                  = s.rst_pin_o;
    assign rst_pin_oe                 = s.rst_pin_oe;
    assign core_rst_req               = s.core_rst_req;
    assign serial_programming_port_en = s.isp_en;
    assign port4_bit3_o               = s.p43_o;
    assign port4_bit3_oe              = s.p43_oe;
    assign gpio_p43_in                = s.p43_gpio_in;
    assign halt_req                   = s.halted;
    assign break_nop_busy             = s.nop_busy;
    assign sfr_mem_we                 = s.mem_we;
    assign sfr_mem_re                 = s.mem_re;
    assign sfr_mem_addr               = s.mem_addr;
    assign sfr_mem_wdata              = s.mem_wdata;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fuse_gates_debug_a: assert property (debug_en_fuse |=> !s.active) // RULE1
        else $error("debug active with enable fuse set");
    lock_forces_off_a: assert property (lock_any |=> !s.active) // RULE7
        else $error("debug active with a lock bit programmed");
    boot_priority_a: assert property (boot_run |=> !s.active) // RULE6
        else $error("debug active while bootloader runs");
    enable_follows_a: assert property ($past(presetn) |-> s.active == $past(en_cond)) // RULE1
        else $error("debug active does not follow its conditions");
    ext_rst_ignored_a: assert property ($past(s.active) |-> !core_rst_req) // RULE4
        else $error("external reset passed while debug active");
    isp_blocked_a: assert property ($past(s.active) && !$past(s.isp_entry) |-> !s.isp_en) // RULE4
        else $error("serial programming open while debug active");
    rst_pulse_cut_a: assert property ($past(s.active) && !$past(por_active) |-> !rst_pin_oe) // RULE8
        else $error("reset pin driven outside power-on while debug active");
    por_pulse_kept_a: assert property (por_active |=> rst_pin_oe && rst_pin_o) // RULE8
        else $error("power-on pulse missing on reset pin");
    p43_port_cut_a: assert property ($past(s.active) |-> port4_bit3_oe == $past(s.dda_oe)) // RULE10
        else $error("port logic drives the debug data pin");
    dda_drive_tx_a: assert property (s.dda_oe |-> s.link == dbe_pkg::DBE_LS_TX) // RULE3
        else $error("debug data driven outside a reply");
    break_nop_two_a: assert property (break_op && !s.active && s.nop_cnt == 2'h0 // RULE11
        |=> break_nop_busy ##1 break_nop_busy ##1 !break_nop_busy)
        else $error("break no-op length wrong");
    break_halts_a: assert property (break_op && s.active |=> halt_req) // RULE16
        else $error("break opcode did not halt");
    wdt_halt_a: assert property (wdt_ovf && s.active && s.ctrl[`DBE_CTRL_WDT] |=> halt_req) // RULE14
        else $error("watchdog break missed");

    halt_by_bkpt_c: cover property (s.active && |bp_hit ##1 halt_req);
    link_read_c: cover property (sfr_mem_re ##[1:40] port4_bit3_oe);
    link_write_c: cover property (sfr_mem_we);
    break_nop_c: cover property (break_op && !s.active ##1 break_nop_busy);
endmodule

// File: verification/dbe_emu.sv
`timescale 1ns/1ps
module dbe_emu (
    input  wire logic pclk,
    input  wire logic pin,
    output logic      debug_clock_pin,
    output logic      d_o,
    output logic      d_oe
);
    initial begin
        debug_clock_pin = 1'h0;
        d_o = 1'h0;
        d_oe = 1'h0;
    end
    // the reset pin is our clock, so a target reset can only go out as a frame
    task automatic frame(input logic wr, input logic [15:0] addr, input logic [7:0] wd,
                         output logic [7:0] rd);
        logic [24:0] f;
        f = {wr, addr, wd};
        rd = 8'h00;
        @(posedge pclk);
        d_oe <= 1'h1;
        for (int i = 24; i >= 0; i--) begin
            debug_clock_pin <= 1'h0;
            d_o <= f[i];
            repeat (4) @(posedge pclk);
            debug_clock_pin <= 1'h1;
            repeat (4) @(posedge pclk);
        end
        d_oe <= 1'h0;
        if (!wr) begin
            for (int i = 0; i < 8; i++) begin
                debug_clock_pin <= 1'h0;
                repeat (4) @(posedge pclk);
                debug_clock_pin <= 1'h1;
                repeat (4) @(posedge pclk);
                // sampled late in the high phase, the bit holds until the next fall
                rd = {rd[6:0], pin};
            end
        end
        debug_clock_pin <= 1'h0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "dbe_regs.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        tog = 1'h0;
    logic        strap, fv, dv, por, wdt, rpo, rpoe, crr, spp, po, poe, go, goe, gin;
    logic        hlt, nop, we, re, emu_dcl, emu_o, emu_oe, pin;
    logic [3:0]  cond;
    logic [4:0]  ev;
    logic [7:0]  paddr, rb, mwd;
    logic [7:0]  mem [256];
    logic [15:0] fa, da, ma;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors, total_checks, n;

    dbe_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .debug_en_fuse(cond[0]), .boot_jump_fuse(~cond[1]),
        .hw_boot_entry(cond[2]), .lock_any(cond[3]), .por_active(por), .wdt_rst_pulse(wdt),
        .rst_pin_i(emu_dcl | strap), .rst_pin_o(rpo), .rst_pin_oe(rpoe), .core_rst_req(crr),
        .serial_programming_port_en(spp), .port4_bit3_i(pin), .port4_bit3_o(po),
        .port4_bit3_oe(poe), .gpio_p43_o(go), .gpio_p43_oe(goe), .gpio_p43_in(gin),
        .break_op(ev[4]), .flow_change(ev[0]), .stack_fault(ev[1]), .wdt_ovf(ev[2]),
        .sys_reset_evt(ev[3]), .fetch_valid(fv), .fetch_addr(fa), .data_valid(dv),
        .data_addr(da), .halt_req(hlt), .break_nop_busy(nop), .sfr_mem_we(we),
        .sfr_mem_re(re), .sfr_mem_addr(ma), .sfr_mem_wdata(mwd), .sfr_mem_rdata(mem[ma[7:0]]));
    dbe_emu emu (.pclk(pclk), .pin(pin), .debug_clock_pin(emu_dcl), .d_o(emu_o), .d_oe(emu_oe));
    // a released data line toggles so a stale bit can never pass as a reply
    assign pin = poe ? po : (emu_oe ? emu_o : tog);

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        tog <= ~tog;
        if (we) mem[ma[7:0]] <= mwd;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, string s);
        apb(1'h0, a, 32'h0);
        chk(rd & m, exp, s);
    endtask
    task rst(input logic s);
        presetn <= 1'h0;
        strap <= s;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        strap <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, strap, fv, dv, por, wdt, go, goe} = '0;
        {cond, ev, paddr, pwdata, fa, da} = '0;
        presetn = 1'h0;
        rst(1'h0);
        rdchk(`DBE_ADDR_CTRL, 32'h0, 32'hFFFFFFFF, "ctrl reset");
        rdchk(`DBE_ADDR_INT_STAT, 32'h0, 32'hFFFFFFFF, "int_stat reset");
        rdchk(`DBE_ADDR_INT_MASK, 32'h0, 32'hFFFFFFFF, "int_mask reset");
        rdchk(`DBE_ADDR_BP_EN, 32'h0, 32'hFFFFFFFF, "bp_en reset");
        rdchk(`DBE_ADDR_STATUS, 32'h1, 32'hFFFFFFFF, "status active");
        apb(1'h0, 8'h18, 32'h0);
        chk(err, 1'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        chk(spp, 1'h0, "prog port off");
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            cond <= 4'h1 << i;
            repeat (3) @(posedge pclk);
            rdchk(`DBE_ADDR_STATUS, 32'h0, 32'h1, "debug blocked");
            chk(spp, 1'h1, "prog port back");
        end
        cond <= 4'h0;
        goe <= 1'h1;
        go <= 1'h1;
        wdt <= 1'h1;
        strap <= 1'h1;
        repeat (6) @(posedge pclk);
        chk({poe, gin, rpoe, crr}, 4'h0, "pins active");
        por <= 1'h1;
        repeat (4) @(posedge pclk);
        chk({rpoe, rpo}, 2'h3, "por pulse kept");
        por <= 1'h0;
        cond <= 4'h1;
        repeat (6) @(posedge pclk);
        chk({poe, po, gin, rpoe, crr}, 5'h1F, "pins inactive");
        {strap, wdt, goe} <= 3'h0;
        $display("test pins done");
        ev <= 5'h10;
        @(posedge pclk);
        ev <= 5'h0;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            n += (nop === 1'h1);
        end
        chk(n, 2, "nop cycles");
        chk(hlt, 1'h0, "no halt off");
        cond <= 4'h0;
        apb(1'h1, `DBE_ADDR_CTRL, 32'hFF);
        rdchk(`DBE_ADDR_CTRL, 32'h6F, 32'hFFFFFFFF, "ctrl wmask");
        apb(1'h1, `DBE_ADDR_CTRL, 32'h0F);
        apb(1'h1, `DBE_ADDR_INT_MASK, 32'h1);
        for (int i = 0; i < 13; i++) begin
            if (i < 5) ev <= 5'h1 << i;
            else begin
                apb(1'h1, `DBE_ADDR_BP_BASE + 8'(4 * (i - 5)), 32'h1000 + i);
                apb(1'h1, `DBE_ADDR_BP_EN, 32'h1 << (i - 5));
                fa <= 16'h1000 + 16'(i);
                da <= 16'h1000 + 16'(i);
                {fv, dv} <= (i < 9) ? 2'h2 : 2'h1;
            end
            @(posedge pclk);
            {ev, fv, dv} <= 7'h0;
            repeat (3) @(posedge pclk);
            chk({hlt, irq}, 2'h3, "halt");
            rdchk(`DBE_ADDR_STATUS, 32'h3, 32'h3, "halted status");
            apb(1'h1, `DBE_ADDR_INT_STAT, 32'h3);
            apb(1'h1, `DBE_ADDR_CTRL, 32'h1F);
            repeat (2) @(posedge pclk);
            chk({hlt, irq}, 2'h0, "resume");
        end
        // pair 0 in mask mode: entry 5 masks the low byte of entry 4
        apb(1'h1, `DBE_ADDR_BP_BASE + 8'h14, 32'hFF);
        apb(1'h1, `DBE_ADDR_BP_EN, 32'h10);
        apb(1'h1, `DBE_ADDR_CTRL, 32'h2F);
        {dv, da} <= {1'h1, 16'h1077};
        @(posedge pclk);
        dv <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(hlt, 1'h1, "pair mask hit");
        apb(1'h1, `DBE_ADDR_CTRL, 32'h1F);
        $display("test halts done");
        emu.frame(1'h1, 16'h0042, 8'hA5, rb);
        repeat (6) @(posedge pclk);
        chk(mem[8'h42], 8'hA5, "link write");
        rdchk(`DBE_ADDR_INT_STAT, 32'h2, 32'h2, "frame event");
        emu.frame(1'h0, 16'h0042, 8'h00, rb);
        chk(rb, 8'hA5, "link read");
        chk(crr, 1'h0, "no core reset");
        $display("test link done");
        rst(1'h1);
        rdchk(`DBE_ADDR_STATUS, 32'h4, 32'h4, "strap entry");
        chk(spp, 1'h1, "prog port strap");
        $display("test strap done");
        tally_and_finish();
    end
endmodule
